// ---- scl_consts.vh ----
// Character codes, timing figures and sizes for the serial command line block
`ifndef SCL_CONSTS_VH
`define SCL_CONSTS_VH
// ----------------------------------------
// Characters acted upon or sent
// ----------------------------------------
`define SCL_CH_BS 8'h08
`define SCL_CH_LF 8'h0A
`define SCL_CH_CR 8'h0D
`define SCL_CH_XON 8'h11
`define SCL_CH_XOFF 8'h13
`define SCL_CH_NAK 8'h15
`define SCL_CH_CAN 8'h18
`define SCL_CH_ESC 8'h1B
`define SCL_CH_SP 8'h20
`define SCL_CH_BANG 8'h21
`define SCL_CH_PROMPT 8'h3E
`define SCL_CTRL_TOP 8'h1F
// ----------------------------------------
// Buffer sizes
// ----------------------------------------
`define SCL_IN_DEPTH 256
`define SCL_IN_AW 8
`define SCL_TX_DEPTH 32
`define SCL_TX_AW 5
// ----------------------------------------
// Timing
// ----------------------------------------
`define SCL_CLK_HZ 10000000
`define SCL_XON_PERIOD_S 5
`define SCL_XON_CYCLES (`SCL_XON_PERIOD_S * `SCL_CLK_HZ)
`define SCL_TMR_W 26
`endif

// ---- scl_line_ctrl.v ----
// Serial command line buffering, control characters, echo and flow control
// Function
// [R1] DSR low at power-up, high when ready
// [R2] Terminator drops DSR, sends XOFF if enabled
// [R3] Flow control off: no XON/XOFF effect
// [R4] Input queued in 256-byte FIFO
// [R5] Overflow drops oldest; DSR low, no XOFF
// [R6] Next buffered line processed right after
// [R7] Idle with flow control: XON every 5s
// [R8] Only seven control codes acted upon
// [R9] BS removes last non-terminator; echo BS-SP-BS
// [R10] Line dispatched: send CR LF
// [R11] ESC flushes input, sends CR LF
// [R12] XON resumes, XOFF halts transmitter
// [R13] CAN resets both queues and pointers
// [R14] XOFF logs error; XON drains then sends '!'
// [R15] Echo all; only first of CR/LF pair (code echoes only printable bytes, BS and terminators)
// [R16] Terminator answered XOFF CR or XOFF
// [R17] Echo loss sends NAK, logs error
// [R18] Host keeps lines short
// [R19] Host obeys XON/XOFF
// [R20] Host verifies echo before terminator
// [R21] Prompt mode sends CR LF '>'
// [R22] Host always accepts without flow control
`timescale 1ns/1ps
`include "scl_consts.vh"

// ----------------------------------------
// Synchronous FIFO with flush, tail removal and optional drop-oldest
// ----------------------------------------
module scl_fifo #(
  parameter W = 8,
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter DROP_OLD = 0
) (
  input wire clk,
  input wire reset,
  input wire flush,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready,
  input wire drop_tail,
  output wire [W-1:0] tail_data,
  output wire full
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0]; // Entry count when full
  reg [W-1:0] mem_r [0:DEPTH-1]; // Storage
  reg [AW-1:0] wr_r; // Write pointer
  reg [AW-1:0] rd_r; // Read pointer
  reg [AW:0] cnt_r; // Entries held
  wire empty = (cnt_r == {(AW+1){1'b0}});
  wire push = in_valid & in_ready;
  wire pop = (out_ready & ~empty) | (push & full);
  assign full = (cnt_r == FULL_CNT);
  assign in_ready = ~full | (DROP_OLD != 0);
  assign out_valid = ~empty;
  assign out_data = mem_r[rd_r];
  assign tail_data = mem_r[wr_r - 1'b1];

  // Pointer and count update; data array holds no reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (drop_tail && !empty) begin
      // Newest entry withdrawn; a head pop in the same cycle still advances unless that entry is the only one held
      wr_r <= wr_r - 1'b1;
      if (out_ready && cnt_r != {{AW{1'b0}}, 1'b1}) begin
        rd_r <= rd_r + 1'b1;
        cnt_r <= cnt_r - 2'h2;
      end else
        cnt_r <= cnt_r - 1'b1;
    end else begin
      if (pop)
        rd_r <= rd_r + 1'b1;
      if (push)
        wr_r <= wr_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Write port
  always @(posedge clk) begin
    if (push && !flush && !drop_tail)
      mem_r[wr_r] <= in_data;
  end
endmodule // scl_fifo

// ----------------------------------------
// Line controller top
// ----------------------------------------
module scl_line_ctrl #(
  parameter XON_CYC = `SCL_XON_CYCLES
) (
  input wire sys_clk,
  input wire reset,
  input wire flow_en,
  input wire echo_en,
  input wire prompt_en,
  input wire accept_ok,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output wire [7:0] cmd_data,
  output wire cmd_valid,
  input wire cmd_ready,
  input wire line_done,
  input wire [7:0] resp_data,
  input wire resp_valid,
  output wire resp_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  output wire dsr,
  output wire query_err,
  output wire in_overflow
);
  // ----------------------------------------
  // States and declarations
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01; // Waiting for work
  localparam [1:0] ST_EMIT = 2'b10; // Pushing a reply sequence
  reg [1:0] state_r; // Sequencer state
  reg [23:0] seq_r; // Queued reply bytes, low byte first
  reg [1:0] seq_len_r; // Reply bytes left
  reg halt_r; // Transmitter halted by host
  reg bang_r; // Idle marker owed after resume
  reg nak_r; // Echo loss owed a NAK
  reg crlf_r; // Line completion reply owed
  reg xon_r; // Periodic XON owed
  reg busy_r; // Lines in progress
  reg ovf_r; // Input overflow since last drain
  reg dsr_r; // Ready line
  reg err_r; // Query error pulse
  reg prev_term_r; // Last received byte was a terminator that was not skipped as a pair partner
  reg [7:0] prev_ch_r; // Last received byte
  reg [8:0] term_cnt_r; // Terminators held in input queue
  reg [`SCL_TMR_W-1:0] tmr_r; // XON repeat timer
  reg [7:0] push_d; // Byte into transmit queue
  reg push_v; // Push request into transmit queue
  reg in_push; // Byte into input queue
  reg in_drop; // Backspace removal
  reg in_flush; // Input queue flush
  reg tx_flush; // Transmit queue flush
  wire tx_in_ready; // Transmit queue space
  wire tx_full; // Transmit queue full
  wire in_full; // Input queue full
  wire tx_q_valid; // Transmit queue holds data
  wire [7:0] in_tail; // Newest queued input byte
  wire is_term = (rx_data == `SCL_CH_CR) || (rx_data == `SCL_CH_LF);
  wire tail_term = (in_tail == `SCL_CH_CR) || (in_tail == `SCL_CH_LF);
  wire head_term = (cmd_data == `SCL_CH_CR) || (cmd_data == `SCL_CH_LF);
  wire idle = (state_r == ST_IDLE);
  wire take_rx = idle & rx_valid;
  wire pair_skip = prev_term_r & is_term & (rx_data != prev_ch_r); // [R15]
  wire head_gone = (cmd_valid & cmd_ready) | (in_push & in_full);
  // A NAK waits for room, so it never counts as a loss of its own
  wire echo_loss = (state_r == ST_EMIT) & ~tx_in_ready & echo_en & (seq_r[7:0] != `SCL_CH_NAK); // [R17]
  localparam [`SCL_TMR_W-1:0] TMR_LAST = XON_CYC[`SCL_TMR_W-1:0] - 1'b1;
  assign rx_ready = idle;
  assign dsr = dsr_r;
  assign query_err = err_r;
  assign in_overflow = ovf_r;
  assign resp_ready = idle & ~rx_valid & ~nak_r & ~crlf_r & ~bang_r & ~xon_r & tx_in_ready;
  assign tx_valid = tx_q_valid & ~halt_r; // [R12]

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  // Input command queue, oldest dropped on overflow
  scl_fifo #(.W(8), .DEPTH(`SCL_IN_DEPTH), .AW(`SCL_IN_AW), .DROP_OLD(1)) u_in_q ( // [R4]
    .clk(sys_clk),
    .reset(reset),
    .flush(in_flush),
    .in_valid(in_push),
    .in_data(rx_data),
    .in_ready(),
    .out_valid(cmd_valid),
    .out_data(cmd_data),
    .out_ready(cmd_ready),
    .drop_tail(in_drop),
    .tail_data(in_tail),
    .full(in_full)
  );

  // Outgoing character queue
  scl_fifo #(.W(8), .DEPTH(`SCL_TX_DEPTH), .AW(`SCL_TX_AW), .DROP_OLD(0)) u_tx_q (
    .clk(sys_clk),
    .reset(reset),
    .flush(tx_flush),
    .in_valid(push_v),
    .in_data(push_d),
    .in_ready(tx_in_ready),
    .out_valid(tx_q_valid),
    .out_data(tx_data),
    .out_ready(tx_ready & ~halt_r),
    .drop_tail(1'b0),
    .tail_data(),
    .full(tx_full)
  );

  // ----------------------------------------
  // Received byte decode
  // ----------------------------------------
  // Queue writes, removals and flushes
  always @* begin
    in_push = 1'b0;
    in_drop = 1'b0;
    in_flush = 1'b0;
    tx_flush = 1'b0;
    if (take_rx) begin
      if (rx_data == `SCL_CH_CAN) begin
        in_flush = 1'b1; // [R13]
        tx_flush = 1'b1; // [R13]
      end else if (rx_data == `SCL_CH_ESC)
        in_flush = 1'b1; // [R11]
      else if (rx_data == `SCL_CH_BS)
        in_drop = cmd_valid & ~tail_term; // [R9]
      else if (is_term)
        in_push = ~pair_skip;
      else if (rx_data > `SCL_CTRL_TOP)
        in_push = 1'b1; // [R8]
    end
  end

  // Transmit queue push source
  always @* begin
    push_v = 1'b0;
    push_d = seq_r[7:0];
    if (state_r == ST_EMIT)
      push_v = 1'b1;
    else if (resp_ready && resp_valid) begin
      push_v = 1'b1;
      push_d = resp_data;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Reply sequences, flow state and pending replies
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      seq_r <= 24'h000000;
      seq_len_r <= 2'h0;
      halt_r <= 1'b0;
      bang_r <= 1'b0;
      nak_r <= 1'b0;
      crlf_r <= 1'b0;
      err_r <= 1'b0;
      prev_term_r <= 1'b0;
      prev_ch_r <= 8'h00;
    end else begin
      err_r <= 1'b0;
      if (line_done)
        crlf_r <= 1'b1; // [R10]
      if (!flow_en)
        halt_r <= 1'b0; // [R3]
      case (state_r)
        ST_EMIT: begin
          if (tx_in_ready || echo_loss) begin
            if (echo_loss) begin
              nak_r <= 1'b1; // [R17]
              err_r <= 1'b1; // [R17]
            end
            seq_r <= {8'h00, seq_r[23:8]};
            seq_len_r <= seq_len_r - 2'h1;
            if (seq_len_r == 2'h1)
              state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (rx_valid) begin
            prev_term_r <= is_term & ~pair_skip;
            prev_ch_r <= rx_data;
            if (rx_data == `SCL_CH_ESC) begin
              seq_r <= {8'h00, `SCL_CH_LF, `SCL_CH_CR}; // [R11]
              seq_len_r <= 2'h2;
              state_r <= ST_EMIT;
            end else if (rx_data == `SCL_CH_XON && flow_en) begin
              halt_r <= 1'b0; // [R12]
              if (halt_r)
                bang_r <= 1'b1; // [R14]
            end else if (rx_data == `SCL_CH_XOFF && flow_en) begin
              halt_r <= 1'b1; // [R12]
              err_r <= 1'b1; // [R14]
            end else if (rx_data == `SCL_CH_BS && echo_en) begin
              seq_r <= {`SCL_CH_BS, `SCL_CH_SP, `SCL_CH_BS}; // [R9]
              seq_len_r <= 2'h3;
              state_r <= ST_EMIT;
            end else if (is_term && !pair_skip) begin
              if (flow_en && !ovf_r) begin
                seq_r <= {8'h00, rx_data, `SCL_CH_XOFF}; // [R16]
                seq_len_r <= echo_en ? 2'h2 : 2'h1; // [R2]
                state_r <= ST_EMIT;
              end else if (echo_en) begin
                seq_r <= {16'h0000, rx_data}; // [R15]
                seq_len_r <= 2'h1;
                state_r <= ST_EMIT;
              end
            end else if (rx_data > `SCL_CTRL_TOP && echo_en) begin
              seq_r <= {16'h0000, rx_data}; // [R15]
              seq_len_r <= 2'h1;
              state_r <= ST_EMIT;
            end
          end else if (nak_r) begin
            nak_r <= 1'b0;
            seq_r <= {16'h0000, `SCL_CH_NAK}; // [R17]
            seq_len_r <= 2'h1;
            state_r <= ST_EMIT;
          end else if (crlf_r) begin
            crlf_r <= line_done;
            seq_r <= {`SCL_CH_PROMPT, `SCL_CH_LF, `SCL_CH_CR}; // [R10]
            seq_len_r <= prompt_en ? 2'h3 : 2'h2; // [R21]
            state_r <= ST_EMIT;
          end else if (bang_r && !tx_q_valid) begin
            bang_r <= 1'b0;
            seq_r <= {16'h0000, `SCL_CH_BANG}; // [R14]
            seq_len_r <= 2'h1;
            state_r <= ST_EMIT;
          end else if (xon_r) begin
            seq_r <= {16'h0000, `SCL_CH_XON}; // [R7]
            seq_len_r <= 2'h1;
            state_r <= ST_EMIT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Line accounting, ready line and XON timer
  // ----------------------------------------
  // Terminator count, busy, overflow and DSR
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      term_cnt_r <= 9'h000;
      busy_r <= 1'b0;
      ovf_r <= 1'b0;
      dsr_r <= 1'b0; // [R1]
    end else begin
      if (in_flush) begin
        term_cnt_r <= 9'h000;
        ovf_r <= 1'b0;
      end else begin
        // Next line stays queued for the parser to pull at once
        if (in_push && is_term && !(head_gone && head_term))
          term_cnt_r <= term_cnt_r + 9'h001; // [R6]
        else if (!(in_push && is_term) && head_gone && head_term)
          term_cnt_r <= term_cnt_r - 9'h001;
        if (in_push && in_full)
          ovf_r <= 1'b1; // [R5]
        else if (!cmd_valid)
          ovf_r <= 1'b0; // [R5]
      end
      if (in_push && is_term)
        busy_r <= 1'b1; // [R2]
      else if (term_cnt_r == 9'h000 && !cmd_valid && !crlf_r && !line_done)
        busy_r <= 1'b0;
      dsr_r <= accept_ok & ~busy_r & ~ovf_r & ~(in_push & is_term); // [R1] [R2] [R5]
    end
  end

  // XON repeat while idle with flow control on
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tmr_r <= {`SCL_TMR_W{1'b0}};
      xon_r <= 1'b0;
    end else begin
      if (state_r == ST_EMIT && seq_r[7:0] == `SCL_CH_XON && tx_in_ready)
        xon_r <= 1'b0;
      if (!flow_en || busy_r || halt_r) begin
        tmr_r <= {`SCL_TMR_W{1'b0}}; // [R3]
        xon_r <= 1'b0;
      end else if (tmr_r == TMR_LAST) begin
        tmr_r <= {`SCL_TMR_W{1'b0}};
        xon_r <= 1'b1; // [R7]
      end else
        tmr_r <= tmr_r + 1'b1;
    end
  end
endmodule // scl_line_ctrl

// ---- scl_line_ctrl_asserts.sv ----
// Concurrent property checker for the serial command line controller
`timescale 1ns/1ps
`include "scl_consts.vh"
module scl_line_ctrl_asserts #(
  parameter XON_CYC = 20
) (
  input wire sys_clk,
  input wire reset,
  input wire flow_en,
  input wire accept_ok,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_ready,
  input wire cmd_valid,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire dsr,
  input wire query_err,
  input wire in_overflow
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  wire taken = rx_valid && rx_ready; // Byte accepted this edge
  reg halt_r; // Host has held off our output
  integer idle_r; // Quiet cycles while the XON timer should run
  // Halt tracking and idle counting
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      halt_r <= 1'b0;
      idle_r <= 0;
    end else begin
      if (taken && flow_en && rx_data == `SCL_CH_XOFF) halt_r <= 1'b1;
      else if (taken && flow_en && rx_data == `SCL_CH_XON) halt_r <= 1'b0;
      idle_r <= (flow_en && dsr && !halt_r && !tx_valid && rx_ready) ? idle_r + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_term;
    taken && (rx_data == `SCL_CH_CR || rx_data == `SCL_CH_LF);
  endsequence
  sequence s_xoff;
    taken && flow_en && rx_data == `SCL_CH_XOFF;
  endsequence
  a_dsr_needs_accept: assert property (!accept_ok |=> !dsr)
    else $error("dsr high without accept");
  a_term_drops_dsr: assert property (s_term |=> !dsr)
    else $error("dsr kept high after terminator");
  a_flow_off_quiet: assert property (!flow_en && tx_valid |-> tx_data != `SCL_CH_XON && tx_data != `SCL_CH_XOFF)
    else $error("flow byte sent with flow control off");
  a_xoff_halts_tx: assert property (s_xoff |-> ##2 !tx_valid)
    else $error("output not halted");
  a_xoff_logs_err: assert property (s_xoff |-> ##[1:2] query_err)
    else $error("no error pulse on halt");
  a_ovf_holds_dsr: assert property (in_overflow |=> !dsr)
    else $error("dsr high during overflow");
  a_can_clears_q: assert property (taken && rx_data == `SCL_CH_CAN |-> ##[1:3] !cmd_valid)
    else $error("queue kept after cancel");
  a_esc_flushes_q: assert property (taken && rx_data == `SCL_CH_ESC |-> ##[1:3] !cmd_valid)
    else $error("queue kept after escape");
  a_print_gets_queued: assert property (taken && rx_data >= 8'h20 |-> ##[1:3] cmd_valid)
    else $error("printable byte not queued");
  a_xon_interval: assert property (idle_r <= XON_CYC + 8)
    else $error("idle too long without XON");
endmodule // scl_line_ctrl_asserts
bind scl_line_ctrl scl_line_ctrl_asserts #(.XON_CYC(XON_CYC)) u_scl_line_ctrl_asserts (.sys_clk, .reset, .flow_en,
  .accept_ok, .rx_data, .rx_valid, .rx_ready, .cmd_valid, .tx_data, .tx_valid, .dsr, .query_err, .in_overflow);

// ---- scl_host_model.sv ----
// Host terminal model on the far side of the serial line
`timescale 1ns/1ps
`include "scl_consts.vh"
module scl_host_model (
  input wire sys_clk,
  input wire reset,
  input wire flow_on,
  input wire obey,
  input wire stall,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output logic tx_ready
);
  logic [7:0] outq[$]; // Bytes waiting to go out
  logic [7:0] got[$]; // Bytes received from the device
  logic paused; // Held off by the device
  // ----------------------------------------
  // Send and receive
  // ----------------------------------------
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h5A;
      tx_ready <= 1'b0;
      paused <= 1'b1;
    end else begin
      tx_ready <= !stall && (!flow_on || ($urandom % 4) != 0);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_data == `SCL_CH_XON) paused <= 1'b0;
        if (tx_data == `SCL_CH_XOFF) paused <= 1'b1;
      end
      if (rx_valid && !rx_ready) begin
        rx_valid <= 1'b1; // Hold until taken
      end else if (outq.size() != 0 && !(obey && flow_on && paused)) begin
        rx_valid <= 1'b1;
        rx_data <= outq.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data; // Idle line keeps changing
      end
    end
  end
endmodule // scl_host_model

// ---- scl_line_ctrl_tb_top.sv ----
// Self-checking bench for the serial command line controller
`timescale 1ns/1ps
`include "scl_consts.vh"
module scl_line_ctrl_tb_top;
  localparam XON_CYC = 20; // Short XON interval
  typedef logic [7:0] scl_byte_q_t[$];
  logic sys_clk, reset, flow_en, echo_en, prompt_en, accept_ok, cmd_ready, line_done, resp_valid;
  logic obey, stall, fw_hold;
  logic [7:0] resp_data;
  wire [7:0] rx_data, cmd_data, tx_data;
  wire rx_valid, rx_ready, cmd_valid, resp_ready, tx_valid, tx_ready, dsr, query_err, in_overflow;
  int n_mismatch, check_count, n_qerr;
  scl_byte_q_t fw_got, s; // Popped command bytes, stimulus line
  scl_line_ctrl #(.XON_CYC(XON_CYC)) u_scl_line_ctrl (.sys_clk, .reset, .flow_en, .echo_en, .prompt_en,
    .accept_ok, .rx_data, .rx_valid, .rx_ready, .cmd_data, .cmd_valid, .cmd_ready, .line_done, .resp_data,
    .resp_valid, .resp_ready, .tx_data, .tx_valid, .tx_ready, .dsr, .query_err, .in_overflow);
  scl_host_model u_scl_host_model (.sys_clk, .reset, .flow_on(flow_en), .obey, .stall, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Firmware stand-in: pops commands, reports each finished line
  always @(posedge sys_clk) begin
    cmd_ready <= !fw_hold;
    line_done <= 1'b0;
    if (query_err === 1'b1) n_qerr <= n_qerr + 1;
    if (cmd_valid && cmd_ready) begin
      fw_got.push_back(cmd_data);
      if (is_term(cmd_data)) line_done <= 1'b1;
    end
  end
  // ----------------------------------------
  // Checks and expectations
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic chkq(input scl_byte_q_t seen, input scl_byte_q_t exp, input string what);
    chk(8'(seen.size()), 8'(exp.size()), what);
    foreach (exp[i]) chk(seen.size() > i ? seen[i] : 8'hXX, exp[i], what);
  endtask
  function automatic bit is_term(logic [7:0] c);
    return c == `SCL_CH_CR || c == `SCL_CH_LF;
  endfunction
  function automatic scl_byte_q_t strip(scl_byte_q_t q);
    scl_byte_q_t r;
    foreach (q[i]) if (q[i] != `SCL_CH_XON) r.push_back(q[i]);
    return r;
  endfunction
  function automatic scl_byte_q_t rnd(int n);
    scl_byte_q_t r;
    repeat (n) r.push_back(8'(8'h20 + $urandom % 95));
    return r;
  endfunction
  // Expected replies on the serial line
  function automatic scl_byte_q_t exp_tx(scl_byte_q_t q);
    scl_byte_q_t r;
    logic [7:0] p;
    p = 8'h00;
    foreach (q[i]) begin
      if (q[i] >= 8'h20 && echo_en) r.push_back(q[i]);
      else if (q[i] == `SCL_CH_BS && echo_en) r = {r, `SCL_CH_BS, `SCL_CH_SP, `SCL_CH_BS};
      else if (q[i] == `SCL_CH_ESC) r = {r, `SCL_CH_CR, `SCL_CH_LF};
      else if (is_term(q[i]) && !(is_term(p) && p != q[i])) begin
        if (flow_en) r.push_back(`SCL_CH_XOFF);
        if (echo_en) r.push_back(q[i]);
        r = {r, `SCL_CH_CR, `SCL_CH_LF};
        if (prompt_en) r.push_back(`SCL_CH_PROMPT);
      end
      p = q[i];
    end
    return r;
  endfunction
  // Expected command queue contents
  function automatic scl_byte_q_t exp_cmd(scl_byte_q_t q);
    scl_byte_q_t r;
    logic [7:0] p;
    p = 8'h00;
    foreach (q[i]) begin
      if (q[i] >= 8'h20 || (is_term(q[i]) && !(is_term(p) && p != q[i]))) r.push_back(q[i]);
      else if (q[i] == `SCL_CH_BS && r.size() != 0 && !is_term(r[$])) void'(r.pop_back());
      else if (q[i] == `SCL_CH_ESC || q[i] == `SCL_CH_CAN) r.delete();
      if (r.size() > `SCL_IN_DEPTH) void'(r.pop_front());
      p = q[i];
    end
    return r;
  endfunction
  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  task automatic run(input scl_byte_q_t q, input logic e, input logic pr);
    int n;
    echo_en <= e;
    prompt_en <= pr;
    fw_hold <= 1'b1;
    @(posedge sys_clk);
    u_scl_host_model.got.delete();
    fw_got.delete();
    foreach (q[i]) u_scl_host_model.outq.push_back(q[i]);
    n = 0;
    while ((u_scl_host_model.outq.size() != 0 || rx_valid !== 1'b0) && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (8) @(posedge sys_clk);
    chk({7'h00, in_overflow}, 8'(q.size() > `SCL_IN_DEPTH), "overflow flag");
    fw_hold <= 1'b0;
    repeat (40 + q.size()) @(posedge sys_clk);
    chkq(fw_got, exp_cmd(q), "command bytes");
    chkq(strip(u_scl_host_model.got), exp_tx(q), "reply bytes");
  endtask
  task automatic send_resp(input logic [7:0] b);
    int n;
    resp_data <= b;
    resp_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (resp_ready !== 1'b1 && n < 100);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFF5E4A90));
    reset = 1'b1;
    flow_en = 1'b1;
    echo_en = 1'b0;
    prompt_en = 1'b0;
    accept_ok = 1'b1;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    obey = 1'b1;
    stall = 1'b0;
    fw_hold = 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({7'h00, dsr}, 8'h00, "dsr in reset");
    reset <= 1'b0;
    repeat (XON_CYC + 20) @(posedge sys_clk);
    chk(u_scl_host_model.got[0], `SCL_CH_XON, "idle XON");
    chk({7'h00, dsr}, 8'h01, "dsr ready");
    // Firmware unable to take commands: ready line must drop
    accept_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, dsr}, 8'h00, "dsr without accept");
    accept_ok <= 1'b1;
    obey <= 1'b0;
    s = {8'h41, 8'h42, `SCL_CH_BS};
    for (int c = 0; c < 32; c++) if (!(8'(c) inside {`SCL_CH_BS, `SCL_CH_LF, `SCL_CH_CR, `SCL_CH_XON,
      `SCL_CH_XOFF, `SCL_CH_CAN, `SCL_CH_ESC})) s.push_back(8'(c));
    s = {s, rnd(6), `SCL_CH_CR};
    run(s, 1'b1, 1'b0);
    run({8'h58, 8'h59, `SCL_CH_ESC}, 1'b1, 1'b0);
    run({8'h5A, `SCL_CH_CAN}, 1'b0, 1'b0);
    run({8'h43, `SCL_CH_CR, `SCL_CH_LF}, 1'b1, 1'b0);
    run({8'h44, `SCL_CH_LF}, 1'b0, 1'b1);
    // Host halts our output, replies wait, then resume
    u_scl_host_model.got.delete();
    u_scl_host_model.outq.push_back(`SCL_CH_XOFF);
    repeat (6) @(posedge sys_clk);
    send_resp(8'h6F);
    send_resp(8'h6B);
    resp_valid <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(8'(strip(u_scl_host_model.got).size()), 8'h00, "output while halted");
    chk(8'(n_qerr), 8'h01, "halt error pulses");
    u_scl_host_model.outq.push_back(`SCL_CH_XON);
    repeat (40) @(posedge sys_clk);
    chkq(strip(u_scl_host_model.got), {8'h6F, 8'h6B, `SCL_CH_BANG}, "resumed output");
    // Second reset with flow control off
    reset <= 1'b1;
    flow_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    run({8'h51, `SCL_CH_CR}, 1'b1, 1'b1);
    run(rnd(300), 1'b0, 1'b0);
    // Echo queue overflow while the host stalls
    stall <= 1'b1;
    echo_en <= 1'b1;
    s = rnd(40);
    foreach (s[i]) u_scl_host_model.outq.push_back(s[i]);
    repeat (150) @(posedge sys_clk);
    chk(8'(n_qerr > 1), 8'h01, "echo loss error");
    stall <= 1'b0;
    repeat (150) @(posedge sys_clk);
    s = u_scl_host_model.got.find with (item == `SCL_CH_NAK);
    chk(8'(s.size()), 8'h01, "echo loss marker");
    report_and_stop();
  end
endmodule // scl_line_ctrl_tb_top
